// ==== hdl/bfsc_defines.svh ====
// constants of the fixed speed brushless motor controller
`ifndef BFSC_DEFINES_SVH
`define BFSC_DEFINES_SVH

// ==========================================================
// clocking
`define BFSC_CLK_FREQ_KHZ     250000
`define BFSC_XTAL_FREQ_KHZ    3580

// ==========================================================
// widths
`define BFSC_CODE_W           15
`define BFSC_ACC_W            16
`define BFSC_PRE_W            8
`define BFSC_SDIV_W           9
`define BFSC_TDIV_W           2
`define BFSC_STEP_W           3

// ==========================================================
// build options and defaults
`define BFSC_SHIFT_DIV_4POLE  384
`define BFSC_SHIFT_DIV_8POLE  192
`define BFSC_TACH_DIV_DEF     1
`define BFSC_LUT_BASE_DEF     16'h741B
`define BFSC_LUT_STEP_DEF     16'h0016
`define BFSC_LUT_STEP_HIGH    16'h0003

// ==========================================================
// reset and drive values
`define BFSC_SINK_OFF         3'h7
`define BFSC_SOURCE_OFF       3'h0
`define BFSC_SOURCE_ALL       3'h7
`define BFSC_STEP_NONE        3'h7

`endif

// ==== hdl/bfsc_pkg.sv ====
// types of the fixed speed brushless motor controller
`include "bfsc_defines.svh"

package bfsc_pkg;

  // ========================================================
  // build-time sensor separation
  typedef enum logic [2:0]
  {
    BFSC_SEP_60,
    BFSC_SEP_120,
    BFSC_SEP_240,
    BFSC_SEP_300,
    BFSC_SEP_90
  } bfsc_sep_t;

  // ========================================================
  // pin groups
  typedef struct packed
  {
    logic a;
    logic b;
    logic c;
  } bfsc_hall_t;

  typedef struct packed
  {
    logic [2:0] sink_n;
    logic [2:0] source;
  } bfsc_drive_t;

  // ========================================================
  // whole state of the controller
  typedef struct packed
  {
    bfsc_hall_t                 hall_s1;
    bfsc_hall_t                 hall_s2;
    logic [1:0]                 ctl_s1;
    logic [1:0]                 ctl_s2;
    logic                       fwd_s1;
    logic                       fwd_s2;
    logic                       tach_prev;
    logic [`BFSC_TDIV_W-1:0]    tach_cnt;
    logic [`BFSC_PRE_W-1:0]     pre_cnt;
    logic [`BFSC_ACC_W-1:0]     acc;
    logic [`BFSC_CODE_W-1:0]    latch;
    logic [`BFSC_CODE_W-1:0]    shreg;
    logic [`BFSC_SDIV_W-1:0]    sdiv_cnt;
    logic [`BFSC_STEP_W-1:0]    step_prev;
    bfsc_drive_t                drive;
  } bfsc_state_t;

endpackage

// ==== hdl/bfsc_top.sv ====
// fixed speed closed loop controller for a brushless dc motor
`include "bfsc_defines.svh"

module bfsc_top
#(
  parameter int                 TACH_SEL  = 0,
  parameter int                 TACH_DIV  = `BFSC_TACH_DIV_DEF,
  parameter int                 SHIFT_DIV = `BFSC_SHIFT_DIV_4POLE,
  parameter bfsc_pkg::bfsc_sep_t SEP      = bfsc_pkg::BFSC_SEP_60,
  parameter logic [`BFSC_ACC_W-1:0] LUT_BASE = `BFSC_LUT_BASE_DEF,
  parameter logic [`BFSC_ACC_W-1:0] LUT_STEP = `BFSC_LUT_STEP_DEF
)
(
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 ARST_N,
  // motor position sensing
  input  wire bfsc_pkg::bfsc_hall_t HALL_SENSE,
  input  wire logic                 FORWARD,
  // protection
  input  wire logic                 OVERCURRENT,
  input  wire logic                 BRAKE,
  // power stage drive
  output bfsc_pkg::bfsc_drive_t     DRIVE
);
  import bfsc_pkg::*;

  // ========================================================
  // derived constants
  // the block emulates the crystal rate by a prescaler, so table
  // contents and divider settings keep their crystal meaning
  localparam int PRESCALE_RAW = `BFSC_CLK_FREQ_KHZ / `BFSC_XTAL_FREQ_KHZ;
  localparam int PRESCALE     = (PRESCALE_RAW < 1) ? 1 : PRESCALE_RAW;
  localparam logic [`BFSC_PRE_W-1:0] PRE_LAST =
    `BFSC_PRE_W'(PRESCALE - 1);
  localparam logic [`BFSC_SDIV_W-1:0] SDIV_LAST =
    `BFSC_SDIV_W'(SHIFT_DIV - 1);
  localparam logic [`BFSC_TDIV_W-1:0] TDIV_LAST =
    `BFSC_TDIV_W'(TACH_DIV - 1);
  localparam logic [`BFSC_ACC_W-1:0] ACC_TOP = '1;
  localparam bit FOUR_PHASE = (SEP == BFSC_SEP_90);
  localparam logic [1:0] CTL_OC = 2'h1;
  localparam logic [1:0] CTL_BRAKE = 2'h2;

  localparam bfsc_state_t ST_RESET = '{
    drive   : '{sink_n : `BFSC_SINK_OFF, source : `BFSC_SOURCE_OFF},
    step_prev : `BFSC_STEP_NONE,
    default : '0
  };

  // ========================================================
  // state
  bfsc_state_t st;
  bfsc_state_t next_st;

  // ========================================================
  // thermometer table: one comparator per output bit
  // an ascending threshold ladder can only ever give a code
  // with its ones packed from bit 0 upward
  logic [`BFSC_CODE_W-1:0] lut_code;

  genvar gi;
  generate
    for (gi = 0; gi < `BFSC_CODE_W; gi++)
    begin : g_lut
      localparam logic [`BFSC_ACC_W:0] THR_WIDE =
        (`BFSC_ACC_W+1)'(LUT_BASE) +
        (`BFSC_ACC_W+1)'(LUT_STEP * gi);
      localparam logic [`BFSC_ACC_W-1:0] THR =
        THR_WIDE[`BFSC_ACC_W] ? ACC_TOP : THR_WIDE[`BFSC_ACC_W-1:0];
      assign lut_code[gi] = (st.acc >= THR);
    end
  endgenerate

  // ========================================================
  // hall code to commutation step, none for illegal codes
  function automatic logic [`BFSC_STEP_W-1:0] hall_step
  (
    input logic [2:0] code
  );
    logic [`BFSC_STEP_W-1:0] s;
    s = `BFSC_STEP_NONE;
    unique case (SEP)
      BFSC_SEP_60:
      begin
        case (code)
          3'h4:    s = 3'h0;
          3'h6:    s = 3'h1;
          3'h7:    s = 3'h2;
          3'h3:    s = 3'h3;
          3'h1:    s = 3'h4;
          3'h0:    s = 3'h5;
          default: s = `BFSC_STEP_NONE;
        endcase
      end
      BFSC_SEP_120:
      begin
        case (code)
          3'h4:    s = 3'h0;
          3'h6:    s = 3'h1;
          3'h2:    s = 3'h2;
          3'h3:    s = 3'h3;
          3'h1:    s = 3'h4;
          3'h5:    s = 3'h5;
          default: s = `BFSC_STEP_NONE;
        endcase
      end
      BFSC_SEP_240:
      begin
        case (code)
          3'h4:    s = 3'h0;
          3'h5:    s = 3'h1;
          3'h1:    s = 3'h2;
          3'h3:    s = 3'h3;
          3'h2:    s = 3'h4;
          3'h6:    s = 3'h5;
          default: s = `BFSC_STEP_NONE;
        endcase
      end
      BFSC_SEP_300:
      begin
        case (code)
          3'h4:    s = 3'h0;
          3'h0:    s = 3'h1;
          3'h1:    s = 3'h2;
          3'h3:    s = 3'h3;
          3'h7:    s = 3'h4;
          3'h6:    s = 3'h5;
          default: s = `BFSC_STEP_NONE;
        endcase
      end
      BFSC_SEP_90:
      begin
        // sensors b and c are strapped together on this variant
        case (code[2:1])
          2'h0:    s = 3'h0;
          2'h2:    s = 3'h1;
          2'h3:    s = 3'h2;
          2'h1:    s = 3'h3;
          default: s = `BFSC_STEP_NONE;
        endcase
      end
    endcase
    return s;
  endfunction

  // ========================================================
  // commutation step to the active sink and source
  function automatic bfsc_drive_t step_drive
  (
    input logic [`BFSC_STEP_W-1:0] s,
    input logic                    fwd
  );
    bfsc_drive_t d;
    logic [2:0]  snk;
    logic [2:0]  src;
    d.sink_n = `BFSC_SINK_OFF;
    d.source = `BFSC_SOURCE_OFF;
    snk = 3'h0;
    src = 3'h0;
    if (FOUR_PHASE)
    begin
      // one output of four at a time: sinks 0, 2 and sources 0, 2
      case ({fwd, s})
        4'h8:    snk = 3'h1;
        4'h9:    snk = 3'h4;
        4'hA:    src = 3'h1;
        4'hB:    src = 3'h4;
        4'h0:    src = 3'h1;
        4'h1:    src = 3'h4;
        4'h2:    snk = 3'h1;
        4'h3:    snk = 3'h4;
        default: snk = 3'h0;
      endcase
    end
    else
    begin
      case (s)
        3'h0:    begin snk = 3'h4; src = 3'h2; end
        3'h1:    begin snk = 3'h4; src = 3'h1; end
        3'h2:    begin snk = 3'h2; src = 3'h1; end
        3'h3:    begin snk = 3'h2; src = 3'h4; end
        3'h4:    begin snk = 3'h1; src = 3'h4; end
        3'h5:    begin snk = 3'h1; src = 3'h2; end
        default: begin snk = 3'h0; src = 3'h0; end
      endcase
      // reverse drives the same winding with the current turned round
      if (!fwd)
      begin
        {snk, src} = {src, snk};
      end
    end
    d.sink_n = ~snk;
    d.source = src;
    return d;
  endfunction

  // ========================================================
  // next state
  logic                    tach_now;
  logic                    tach_edge;
  logic                    tach_event;
  logic                    xtal_tick;
  logic                    shift_tick;
  logic [`BFSC_STEP_W-1:0] step_now;
  logic                    commutate;
  logic                    oc;
  logic                    brk;

  always_comb
  begin
    next_st = st;

    // two-stage synchronisers on every pin
    next_st.hall_s1 = HALL_SENSE;
    next_st.hall_s2 = st.hall_s1;
    next_st.ctl_s1  = {BRAKE, OVERCURRENT};
    next_st.ctl_s2  = st.ctl_s1;
    next_st.fwd_s1  = FORWARD;
    next_st.fwd_s2  = st.fwd_s1;
    oc  = |(st.ctl_s2 & CTL_OC);
    brk = |(st.ctl_s2 & CTL_BRAKE);

    // tachometer pick and falling edge
    unique case (TACH_SEL)
      1:       tach_now = st.hall_s2.b;
      2:       tach_now = st.hall_s2.c;
      default: tach_now = st.hall_s2.a;
    endcase
    next_st.tach_prev = tach_now;
    tach_edge  = st.tach_prev & ~tach_now;
    tach_event = tach_edge && (st.tach_cnt == TDIV_LAST);
    if (tach_edge)
    begin
      next_st.tach_cnt = tach_event ? '0 : st.tach_cnt + 1'b1;
    end

    // crystal-rate tick from the system clock
    xtal_tick = (st.pre_cnt == PRE_LAST);
    next_st.pre_cnt = xtal_tick ? '0 : st.pre_cnt + 1'b1;

    // period accumulator and latch bank
    if (tach_event)
    begin
      next_st.latch = lut_code;
      next_st.acc   = '0;
    end
    else if (xtal_tick && (st.acc != ACC_TOP))
    begin
      next_st.acc = st.acc + 1'b1;
    end

    // commutation detect
    step_now = hall_step({st.hall_s2.a, st.hall_s2.b, st.hall_s2.c});
    next_st.step_prev = step_now;
    commutate = (step_now != st.step_prev);

    // shift register and its clock divider
    shift_tick = xtal_tick && (st.sdiv_cnt == SDIV_LAST);
    if (commutate)
    begin
      next_st.shreg    = st.latch;
      next_st.sdiv_cnt = '0;
    end
    else
    begin
      if (xtal_tick)
      begin
        next_st.sdiv_cnt = shift_tick ? '0 : st.sdiv_cnt + 1'b1;
      end
      if (shift_tick)
      begin
        // top bit refills: an all-ones code stays on for the whole
        // interval, any other code runs out to zeros and stays off
        next_st.shreg = {st.shreg[`BFSC_CODE_W-1],
                         st.shreg[`BFSC_CODE_W-1:1]};
      end
    end

    // output drive, protection first
    if (oc)
    begin
      next_st.drive.sink_n = `BFSC_SINK_OFF;
      next_st.drive.source = `BFSC_SOURCE_OFF;
    end
    else if (brk)
    begin
      next_st.drive.sink_n = `BFSC_SINK_OFF;
      next_st.drive.source = `BFSC_SOURCE_ALL;
    end
    else if (next_st.shreg[0])
    begin
      // direction comes through its own synchroniser like the sensors
      next_st.drive = step_drive(step_now, st.fwd_s2);
    end
    else
    begin
      next_st.drive.sink_n = `BFSC_SINK_OFF;
      next_st.drive.source = `BFSC_SOURCE_OFF;
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st <= ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign DRIVE = st.drive;

endmodule

// ==== bench/bfsc_motor.sv ====
// hall sensor and power stage model of a three-phase motor
module bfsc_motor
(
  // clock
  input  wire logic                  clk,
  // motion
  input  wire logic                  fwd,
  input  wire logic [15:0]           period,
  // power stage and sensors
  input  wire bfsc_pkg::bfsc_drive_t drive,
  output bfsc_pkg::bfsc_hall_t       hall,
  output int                         on_last
);
  timeunit 1ns;
  timeprecision 1ps;
  import bfsc_pkg::*;

  // ====
  // sensors 60 degrees apart, sensor a falls once per turn
  localparam logic [2:0] SEQ [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  int cnt = 0;
  int st = 0;
  int on_cnt = 0;
  int on_done = 0;

  assign hall = SEQ[st];
  assign on_last = on_done;

  // the rotor turns at a set rate whatever the drive does
  always @(negedge clk)
  begin
    on_cnt += int'(drive.sink_n != 3'h7);
    cnt++;
    if (cnt >= int'(period))
    begin
      cnt = 0;
      on_done = on_cnt;
      on_cnt = 0;
      st = fwd ? (st + 1) % 6 : (st + 5) % 6;
    end
  end
endmodule

// ==== bench/bfsc_top_sva.sv ====
// assertions on the pins of the speed controller
`include "bfsc_defines.svh"
module bfsc_chk
(
  // clock and reset
  input wire logic                  CLK,
  input wire logic                  ARST_N,
  // sensing and protection
  input wire bfsc_pkg::bfsc_hall_t  HALL_SENSE,
  input wire logic                  FORWARD,
  input wire logic                  OVERCURRENT,
  input wire logic                  BRAKE,
  // power stage
  input wire bfsc_pkg::bfsc_drive_t DRIVE
);
  import bfsc_pkg::*;

  // ====
  // ages of the last hall change and of the last protection request
  logic                 on;
  bfsc_hall_t           hall_d;
  logic [3:0]           q_hall;
  logic [3:0]           q_prot;

  assign on = DRIVE.sink_n != `BFSC_SINK_OFF;

  // ages saturate so long quiet spells stay comparable
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      hall_d <= '0;
      q_hall <= 4'h0;
      q_prot <= 4'h0;
    end
    else
    begin
      hall_d <= HALL_SENSE;
      q_hall <= (HALL_SENSE != hall_d) ? 4'h0 : q_hall + 4'(q_hall != 4'hF);
      q_prot <= (OVERCURRENT || BRAKE) ? 4'h0 : q_prot + 4'(q_prot != 4'hF);
    end
  end

  // ====
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_oc_cuts_off:
    assert property (OVERCURRENT [*3] |=> DRIVE == 6'h38)
    else $error("drive not cut off in overcurrent");
  a_oc_over_brake:
    assert property ((OVERCURRENT && BRAKE) [*3] |=> DRIVE.source == 3'h0)
    else $error("brake won over overcurrent");
  a_brake_shorts:
    assert property ((BRAKE && !OVERCURRENT) [*3] |=> DRIVE == 6'h3F)
    else $error("brake did not short the windings");
  a_one_sink:
    assert property ((!BRAKE) [*4] |-> $onehot0(~DRIVE.sink_n))
    else $error("more than one sink on");
  a_one_source:
    assert property ((!BRAKE) [*4] |-> $onehot0(DRIVE.source))
    else $error("more than one source on");
  a_pair_gated:
    assert property ((!BRAKE && !OVERCURRENT) [*4] |->
                     on == (DRIVE.source != 3'h0))
    else $error("sink and source not gated together");
  a_rise_at_step:
    assert property ($rose(on) && q_prot > 4'h7 |-> q_hall < 4'h5)
    else $error("winding turned on away from a commutation");
  a_reset_off:
    assert property (disable iff (1'b0) !ARST_N |-> DRIVE == 6'h38)
    else $error("drive not off in reset");
endmodule

bind bfsc_top bfsc_chk u_chk
(
  .CLK         (CLK),
  .ARST_N      (ARST_N),
  .HALL_SENSE  (HALL_SENSE),
  .FORWARD     (FORWARD),
  .OVERCURRENT (OVERCURRENT),
  .BRAKE       (BRAKE),
  .DRIVE       (DRIVE)
);

// ==== bench/testbench.sv ====
// self-checking bench of the fixed speed controller
`include "bfsc_defines.svh"
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bfsc_pkg::*;

  // ====
  localparam int TICK = `BFSC_CLK_FREQ_KHZ / `BFSC_XTAL_FREQ_KHZ;
  localparam int SHD  = 4;
  localparam int BASE = 64;
  logic        clk = 1'b0;
  logic        arst_n = 1'b1;
  logic        fwd = 1'b1;
  logic        oc = 1'b0;
  logic        brk = 1'b0;
  logic [15:0] period = 16'h04B0;
  logic [31:0] seed = 32'h0000_0046;
  bfsc_hall_t  hall;
  bfsc_drive_t drive;
  int          on_last;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #2 clk = ~clk;

  bfsc_top #(.TACH_SEL(0), .TACH_DIV(1), .SHIFT_DIV(SHD),
    .SEP(BFSC_SEP_60), .LUT_BASE(16'h0040), .LUT_STEP(16'h0001))
  u_bfsc_top (.CLK(clk), .ARST_N(arst_n), .HALL_SENSE(hall),
    .FORWARD(fwd), .OVERCURRENT(oc), .BRAKE(brk), .DRIVE(drive));

  bfsc_motor u_motor (.clk(clk), .fwd(fwd), .period(period),
    .drive(drive), .hall(hall), .on_last(on_last));

  // ====
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // ones latched for a tach period of acc crystal ticks
  function automatic int ones(int acc);
    return acc < BASE ? 0 : (acc > BASE + 13 ? 15 : acc - BASE + 1);
  endfunction

  // on cycles per commutation; all ones, or a code that outlasts the
  // interval, keeps the winding on for the whole of it
  function automatic int on_time(int n, int p);
    return (n == 15 || n * SHD * TICK >= p) ? p : n * SHD * TICK;
  endfunction

  // prescaler phase may add one tick to the period count, and the
  // first shift period is short by up to one tick
  function automatic int expect_on(int g, int p);
    int lo;
    int e0;
    int e1;
    lo = (6 * p - 1) / TICK;
    e0 = on_time(ones(lo), p);
    e1 = on_time(ones(lo + 1), p);
    if (g >= e1 - TICK && g <= e1 + 1)
      return g;
    return (g >= e0 - TICK && g <= e0 + 1) ? g : e0;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic spin(int n);
    repeat (n) @(negedge clk);
  endtask

  // on time per commutation from the thermometer count of one turn
  task automatic speed(logic [15:0] p);
    period = p;
    fwd = 1'(xs());
    spin(26 * int'(p));
    `CHK(on_last, expect_on(on_last, int'(p)))
    $display("speed test period %0d done", p);
  endtask

  task automatic protect(logic o, logic b);
    bfsc_drive_t e;
    e = o ? {`BFSC_SINK_OFF, `BFSC_SOURCE_OFF}
          : {`BFSC_SINK_OFF, `BFSC_SOURCE_ALL};
    oc = o;
    brk = b;
    spin(4 + int'(xs() % 8));
    `CHK(drive, e)
    oc = 1'b0;
    brk = 1'b0;
    spin(4);
    `CHK(drive.sink_n != 3'h7, 1'b1)
    $display("protection test %b%b done", o, b);
  endtask

  // ====
  // reset lands between edges, so no edge sees an unreset drive
  initial
  begin
    #1;
    arst_n = 1'b0;
    spin(12);
    arst_n = 1'b1;
    speed(16'h04B0);
    protect(1'b1, 1'b0);
    protect(1'b0, 1'b1);
    protect(1'b1, 1'b1);
    speed(16'h02E4);
    speed(16'h0258);
    end_sim();
  end

  // the tests need some 66100 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  end
endmodule
